// ### hdl/sfed_top.sv
`timescale 1ns/1ns
`include "sfed_map.svh"

// Function
// - parity codes none/even/odd/one/zero, default none
// - forced-one parity bit mimics second stop bit
// - exactly one stop bit, no two-stop option
// - parity generated on transmit, never checked
// - programming mode always uses no parity
// - width code 0 seven, 1 eight, default eight
// - programming mode always uses eight bits
// - cfg settings apply at reset or programming exit
// - active override parity beats stored parity
// - escape type off/timed/prefix, default off
// - timed escape: three 01H after long gaps
// - long-gap 01H counted, not stored
// - short-gap 01H stored, count cleared
// - counted 01H of abandoned escape are lost
// - prefix escape: 01H then non-01H enters
// - prefix 01H 01H stores one 01H
// - button entry forces 38400, escape keeps baud
module sfed_top
#(
	parameter int GAP_CYCLES = `SFED_GAP_CYCLES
)
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        serial_rx_in,
	output logic             serial_tx_out,
	input  wire logic        setup_button_in,
	output logic [7:0]       rx_data_out,
	output logic             rx_store_out,
	output logic             rx_cmd_out,
	output logic             prog_mode_out
);
	// ====================================================================
	// declarations
	sfed_pkg::sfed_par_t parity_select_q;
	logic                data_width_select_q;
	sfed_pkg::sfed_esc_t escape_type_select_q;
	logic                ovr_en_q;
	sfed_pkg::sfed_par_t ovr_par_q;
	logic [15:0]         baud_div_q;
	sfed_pkg::sfed_par_t act_par_q;
	logic                act_wid_q;
	sfed_pkg::sfed_esc_t act_esc_q;
	logic                prog_q;
	logic                by_button_q;
	logic                btn1_q;
	logic                btn2_q;
	logic                btn3_q;
	logic [23:0]         gap_q;
	logic                gap_long_q;
	logic [1:0]          esc_cnt_q;
	logic                pend_q;
	logic                tx_busy_q;
	logic [10:0]         tx_sh_q;
	logic [3:0]          tx_left_q;
	logic [15:0]         tx_cnt_q;
	logic                wr_acc;
	logic                exit_req;
	logic                eff_w8;
	sfed_pkg::sfed_par_t eff_par;
	logic [15:0]         div_eff;
	logic                rx_start;
	logic                rx_done;
	logic [7:0]          rx_byte;
	logic [31:0]         rd_d;
	logic                known;

	localparam logic [23:0] GAP_LIM = 24'(GAP_CYCLES);
	localparam logic [15:0] BTN_DIV = 16'(`SFED_BTN_DIV);

	// ====================================================================
	// helpers
	function automatic logic sfed_par_bit(input logic [7:0] d, input logic w8,
		input sfed_pkg::sfed_par_t p);
		logic x;
		x = ^(w8 ? d : {1'b0, d[6:0]});
		case (p)
			`SFED_PAR_EVEN: sfed_par_bit = x;
			`SFED_PAR_ODD:  sfed_par_bit = ~x;
			`SFED_PAR_ONE:  sfed_par_bit = 1'b1;
			default:        sfed_par_bit = 1'b0;
		endcase
	endfunction : sfed_par_bit

	// frame is sent lsb first: start, data, optional parity, one stop
	function automatic logic [10:0] sfed_frame(input logic [7:0] d, input logic w8,
		input sfed_pkg::sfed_par_t p);
		logic [10:0] f;
		f      = 11'h7FF;
		f[0]   = 1'b0;
		f[7:1] = d[6:0];
		if (w8)
			f[8] = d[7];
		if (p != `SFED_PAR_NONE)
		begin
			if (w8)
				f[9] = sfed_par_bit(d, w8, p);
			else
				f[8] = sfed_par_bit(d, w8, p);
		end
		sfed_frame = f;
	endfunction : sfed_frame

	function automatic logic [3:0] sfed_frame_len(input logic w8, input sfed_pkg::sfed_par_t p);
		sfed_frame_len = 4'h9 + {3'h0, w8} + {3'h0, p != `SFED_PAR_NONE};
	endfunction : sfed_frame_len

	// ====================================================================
	// effective framing
	always_comb
	begin
		if (prog_q)
		begin
			eff_w8  = 1'b1;
			eff_par = `SFED_PAR_NONE;
		end
		else
		begin
			eff_w8  = act_wid_q;
			eff_par = ovr_en_q ? ovr_par_q : act_par_q;
		end
		div_eff = (prog_q && by_button_q) ? BTN_DIV : baud_div_q;
	end

	// ====================================================================
	// apb slave: no wait states, ready in the first access cycle, every output is a flop
	assign wr_acc   = psel_in && penable_in && pready_out && pwrite_in;
	assign exit_req = wr_acc && (paddr_in == `SFED_ADDR_CTRL) && pwdata_in[`SFED_CTRL_EXIT_BIT];

	always_comb
	begin
		rd_d  = 32'h0000_0000;
		known = 1'b1;
		if (paddr_in == `SFED_ADDR_CFG)
		begin
			rd_d[`SFED_CFG_PAR_LSB +: 3] = parity_select_q;
			rd_d[`SFED_CFG_WID_BIT]      = data_width_select_q;
			rd_d[`SFED_CFG_ESC_LSB +: 2] = escape_type_select_q;
		end
		else if (paddr_in == `SFED_ADDR_OVR)
		begin
			rd_d[`SFED_OVR_EN_BIT]        = ovr_en_q;
			rd_d[`SFED_OVR_PAR_LSB +: 3]  = ovr_par_q;
		end
		else if (paddr_in == `SFED_ADDR_BAUD)
			rd_d[15:0] = baud_div_q;
		else if (paddr_in == `SFED_ADDR_CTRL)
			rd_d = 32'h0000_0000;
		else if (paddr_in == `SFED_ADDR_STAT)
			rd_d[11:0] = {tx_busy_q, pend_q, esc_cnt_q, act_esc_q, eff_w8, eff_par,
				by_button_q, prog_q};
		else if (paddr_in == `SFED_ADDR_TXD)
			rd_d[0] = tx_busy_q;
		else
			known = 1'b0;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end
		else
		begin
			pready_out  <= psel_in && !penable_in && !pready_out;
			pslverr_out <= psel_in && !penable_in && !pready_out && !known;
			prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? rd_d : 32'h0000_0000;
		end
	end

	// stored settings: written freely; cfg not in force until exit, override and baud act at once
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			parity_select_q      <= `SFED_RST_PAR;
			data_width_select_q  <= `SFED_RST_WID;
			escape_type_select_q <= `SFED_RST_ESC;
			ovr_en_q             <= 1'b0;
			ovr_par_q            <= `SFED_PAR_NONE;
			baud_div_q           <= BTN_DIV;
		end
		else if (wr_acc)
		begin
			if (paddr_in == `SFED_ADDR_CFG)
			begin
				// out-of-range codes are refused and the old value kept
				if (pwdata_in[`SFED_CFG_PAR_LSB +: 3] <= `SFED_PAR_ZERO)
					parity_select_q <= pwdata_in[`SFED_CFG_PAR_LSB +: 3];
				data_width_select_q <= pwdata_in[`SFED_CFG_WID_BIT];
				if (pwdata_in[`SFED_CFG_ESC_LSB +: 2] <= `SFED_ESC_PREFIX)
					escape_type_select_q <= pwdata_in[`SFED_CFG_ESC_LSB +: 2];
			end
			else if (paddr_in == `SFED_ADDR_OVR)
			begin
				ovr_en_q <= pwdata_in[`SFED_OVR_EN_BIT];
				if (pwdata_in[`SFED_OVR_PAR_LSB +: 3] <= `SFED_PAR_ZERO)
					ovr_par_q <= pwdata_in[`SFED_OVR_PAR_LSB +: 3];
			end
			else if (paddr_in == `SFED_ADDR_BAUD && pwdata_in[15:0] >= 16'h0004)
				baud_div_q <= pwdata_in[15:0];
		end
	end

	// active settings follow the stored ones only on reset or exit
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			act_par_q <= `SFED_RST_PAR;
			act_wid_q <= `SFED_RST_WID;
			act_esc_q <= `SFED_RST_ESC;
		end
		else if (exit_req && prog_q)
		begin
			act_par_q <= parity_select_q;
			act_wid_q <= data_width_select_q;
			act_esc_q <= escape_type_select_q;
		end
	end

	// ====================================================================
	// receiver and gap timer
	sfed_uart_rx u_rx
	(
		.clk_sys_in (clk_sys_in),
		.rst_in     (rst_in),
		.serial_in  (serial_rx_in),
		.div_in     (div_eff),
		.bits8_in   (eff_w8),
		.par_en_in  (eff_par != `SFED_PAR_NONE),
		.start_out  (rx_start),
		.done_out   (rx_done),
		.data_out   (rx_byte)
	);

	// the gap counter starts saturated so the first character after reset sees a long gap
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			gap_q      <= GAP_LIM;
			gap_long_q <= 1'b1;
		end
		else
		begin
			if (rx_done)
				gap_q <= 24'h00_0000;
			else if (gap_q < GAP_LIM)
				gap_q <= gap_q + 24'h00_0001;
			if (rx_start)
				gap_long_q <= (gap_q >= GAP_LIM);
		end
	end

	// ====================================================================
	// button synchroniser
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			btn1_q <= 1'b0;
			btn2_q <= 1'b0;
			btn3_q <= 1'b0;
		end
		else
		begin
			btn1_q <= setup_button_in;
			btn2_q <= btn1_q;
			btn3_q <= btn2_q;
		end
	end

	// ====================================================================
	// escape detection and routing of received characters
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prog_q       <= 1'b0;
			by_button_q  <= 1'b0;
			esc_cnt_q    <= 2'h0;
			pend_q       <= 1'b0;
			rx_data_out  <= 8'h00;
			rx_store_out <= 1'b0;
			rx_cmd_out   <= 1'b0;
		end
		else
		begin
			rx_store_out <= 1'b0;
			rx_cmd_out   <= 1'b0;
			if (btn2_q && !btn3_q && !prog_q)
			begin
				prog_q      <= 1'b1;
				by_button_q <= 1'b1;
				esc_cnt_q   <= 2'h0;
				pend_q      <= 1'b0;
			end
			else if (exit_req && prog_q)
			begin
				prog_q      <= 1'b0;
				by_button_q <= 1'b0;
			end
			else if (rx_done)
			begin
				rx_data_out <= rx_byte;
				if (prog_q)
					rx_cmd_out <= 1'b1;
				else if (act_esc_q == `SFED_ESC_TIMED)
				begin
					if (rx_byte == `SFED_ESC_CHAR && gap_long_q)
					begin
						if (esc_cnt_q == 2'h2)
						begin
							prog_q    <= 1'b1;
							esc_cnt_q <= 2'h0;
						end
						else
							esc_cnt_q <= esc_cnt_q + 2'h1;
					end
					else
					begin
						rx_store_out <= 1'b1;
						esc_cnt_q    <= 2'h0;
					end
				end
				else if (act_esc_q == `SFED_ESC_PREFIX)
				begin
					if (!pend_q)
					begin
						if (rx_byte == `SFED_ESC_CHAR)
							pend_q <= 1'b1;
						else
							rx_store_out <= 1'b1;
					end
					else
					begin
						pend_q <= 1'b0;
						if (rx_byte == `SFED_ESC_CHAR)
							rx_store_out <= 1'b1;
						else
							prog_q <= 1'b1;
					end
				end
				else
					rx_store_out <= 1'b1;
			end
		end
	end

	// ====================================================================
	// transmitter; a write while busy is dropped, software polls the busy bit
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tx_busy_q     <= 1'b0;
			tx_sh_q       <= 11'h7FF;
			tx_left_q     <= 4'h0;
			tx_cnt_q      <= 16'h0000;
			serial_tx_out <= 1'b1;
		end
		else if (!tx_busy_q)
		begin
			serial_tx_out <= 1'b1;
			if (wr_acc && paddr_in == `SFED_ADDR_TXD)
			begin
				tx_busy_q <= 1'b1;
				tx_sh_q   <= sfed_frame(pwdata_in[7:0], eff_w8, eff_par);
				tx_left_q <= sfed_frame_len(eff_w8, eff_par);
				tx_cnt_q  <= 16'h0000;
			end
		end
		else
		begin
			serial_tx_out <= tx_sh_q[0];
			if (tx_cnt_q >= div_eff - 16'h0001)
			begin
				tx_cnt_q  <= 16'h0000;
				tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
				tx_left_q <= tx_left_q - 4'h1;
				if (tx_left_q == 4'h1)
					tx_busy_q <= 1'b0;
			end
			else
				tx_cnt_q <= tx_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			prog_mode_out <= 1'b0;
		else
			prog_mode_out <= prog_q;
	end
endmodule : sfed_top

// ### hdl/sfed_map.svh
`ifndef SFED_MAP_SVH
`define SFED_MAP_SVH

// ====================================================================
// register byte offsets
`define SFED_ADDR_CFG      8'h00
`define SFED_ADDR_OVR      8'h04
`define SFED_ADDR_BAUD     8'h08
`define SFED_ADDR_CTRL     8'h0C
`define SFED_ADDR_STAT     8'h10
`define SFED_ADDR_TXD      8'h14

// ====================================================================
// field positions
`define SFED_CFG_PAR_LSB   0
`define SFED_CFG_WID_BIT   3
`define SFED_CFG_ESC_LSB   4
`define SFED_OVR_EN_BIT    0
`define SFED_OVR_PAR_LSB   1
`define SFED_CTRL_EXIT_BIT 0

// ====================================================================
// codes and reset values
`define SFED_PAR_NONE      3'h0
`define SFED_PAR_EVEN      3'h1
`define SFED_PAR_ODD       3'h2
`define SFED_PAR_ONE       3'h3
`define SFED_PAR_ZERO      3'h4
`define SFED_WID_7         1'h0
`define SFED_WID_8         1'h1
`define SFED_ESC_OFF       2'h0
`define SFED_ESC_TIMED     2'h1
`define SFED_ESC_PREFIX    2'h2
`define SFED_RST_PAR       3'h0
`define SFED_RST_WID       1'h1
`define SFED_RST_ESC       2'h0
`define SFED_ESC_CHAR      8'h01

// ====================================================================
// timing
`define SFED_CLK_HZ        125000000
`define SFED_GAP_MS        100
`define SFED_GAP_CYCLES    (`SFED_GAP_MS * (`SFED_CLK_HZ / 1000))
`define SFED_BTN_BAUD      38400
`define SFED_BTN_DIV       (`SFED_CLK_HZ / `SFED_BTN_BAUD)

`endif

// ### hdl/sfed_pkg.sv
package sfed_pkg;
	typedef logic [2:0] sfed_par_t;
	typedef logic [1:0] sfed_esc_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} sfed_rx_st_e;
endpackage : sfed_pkg

// ### hdl/sfed_uart_rx.sv
`timescale 1ns/1ns
module sfed_uart_rx
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        serial_in,
	input  wire logic [15:0] div_in,
	input  wire logic        bits8_in,
	input  wire logic        par_en_in,
	output logic             start_out,
	output logic             done_out,
	output logic [7:0]       data_out
);
	logic                 s1_q;
	logic                 s2_q;
	logic                 s3_q;
	sfed_pkg::sfed_rx_st_e st_q;
	logic [15:0]          cnt_q;
	logic [2:0]           idx_q;
	logic [7:0]           sh_q;

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end
		else
		begin
			s1_q <= serial_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// ====================================================================
	// frame receiver; parity bit is skipped, never checked
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_q      <= sfed_pkg::RX_IDLE;
			cnt_q     <= 16'h0000;
			idx_q     <= 3'h0;
			sh_q      <= 8'h00;
			start_out <= 1'b0;
			done_out  <= 1'b0;
			data_out  <= 8'h00;
		end
		else
		begin
			start_out <= 1'b0;
			done_out  <= 1'b0;
			cnt_q     <= cnt_q + 16'h0001;
			case (st_q)
				sfed_pkg::RX_IDLE:
				begin
					cnt_q <= 16'h0000;
					if (s3_q && !s2_q)
					begin
						st_q      <= sfed_pkg::RX_START;
						start_out <= 1'b1;
					end
				end
				sfed_pkg::RX_START:
					if (cnt_q >= {1'b0, div_in[15:1]})
					begin
						cnt_q <= 16'h0000;
						idx_q <= 3'h0;
						// a glitch shorter than half a bit is not a start
						st_q  <= s2_q ? sfed_pkg::RX_IDLE : sfed_pkg::RX_DATA;
					end
				sfed_pkg::RX_DATA:
					if (cnt_q >= div_in - 16'h0001)
					begin
						cnt_q <= 16'h0000;
						sh_q  <= {s2_q, sh_q[7:1]};
						idx_q <= idx_q + 3'h1;
						if (idx_q == (bits8_in ? 3'h7 : 3'h6))
							st_q <= par_en_in ? sfed_pkg::RX_PAR : sfed_pkg::RX_STOP;
					end
				sfed_pkg::RX_PAR:
					if (cnt_q >= div_in - 16'h0001)
					begin
						cnt_q <= 16'h0000;
						st_q  <= sfed_pkg::RX_STOP;
					end
				sfed_pkg::RX_STOP:
					// stay to the end of the stop bit so the gap starts there
					if (cnt_q >= div_in + {1'b0, div_in[15:1]} - 16'h0001)
					begin
						st_q     <= sfed_pkg::RX_IDLE;
						done_out <= 1'b1;
						data_out <= bits8_in ? sh_q : {1'b0, sh_q[7:1]};
					end
				default:
					st_q <= sfed_pkg::RX_IDLE;
			endcase
		end
	end
endmodule : sfed_uart_rx

// ### bench/sfed_top_checker.sv
`timescale 1ns/1ns
module sfed_top_checker
#(
	parameter int GAP_CYCLES = 200
)
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] prdata_out,
	input  wire logic        pready_out,
	input  wire logic        pslverr_out,
	input  wire logic        setup_button_in,
	input  wire logic        rx_store_out,
	input  wire logic        rx_cmd_out,
	input  wire logic        prog_mode_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	// ================================================================
	// register bus
	apb_answer_a: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no ready after setup");
	ready_single_a: assert property (pready_out |=> !pready_out)
		else $error("ready held too long");
	unmapped_err_a: assert property (psel_in && !penable_in && paddr_in > 8'h14
		|=> pslverr_out && prdata_out == 32'h0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (psel_in && !penable_in && paddr_in <= 8'h14
		&& paddr_in[1:0] == 2'h0 |=> !pslverr_out)
		else $error("mapped access refused");
	// ================================================================
	// receive path
	store_pulse_a: assert property (rx_store_out |=> !rx_store_out)
		else $error("store pulse too long");
	store_routing_a: assert property (rx_store_out |-> !prog_mode_out)
		else $error("store while programming");
	cmd_in_prog_a: assert property (rx_cmd_out |-> prog_mode_out && !rx_store_out)
		else $error("command char outside programming");
	button_entry_a: assert property ($rose(setup_button_in) |-> ##[1:8] prog_mode_out)
		else $error("button did not enter programming");
endmodule : sfed_top_checker

bind sfed_top sfed_top_checker #(.GAP_CYCLES(GAP_CYCLES)) chk_i (.clk_sys_in(clk_sys_in),
	.rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.setup_button_in(setup_button_in), .rx_store_out(rx_store_out),
	.rx_cmd_out(rx_cmd_out), .prog_mode_out(prog_mode_out));

// ### bench/sfed_dev_model.sv
`timescale 1ns/1ns
module sfed_dev_model
(
	input  wire logic clk_in,
	input  wire logic line_in,
	output logic      line_out
);
	initial line_out = 1'b1;
	// ================================================================
	// sender: the line rests high between frames
	task automatic put(input logic b, input int div);
		@(posedge clk_in);
		line_out <= b;
		repeat (div - 1) @(posedge clk_in);
	endtask : put
	task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic pv,
		input int div);
		put(1'b0, div);
		for (int i = 0; i < nb; i++)
			put(d[i], div);
		if (pe)
			put(pv, div);
		put(1'b1, div);
	endtask : send
	// ================================================================
	// receiver: samples 11 bit centres, start bit first
	task automatic grab(input int div, output logic [10:0] f);
		// a line that never starts a frame is caught by the bench watchdog
		while (line_in !== 1'b0)
			@(posedge clk_in);
		repeat (div / 2) @(posedge clk_in);
		for (int i = 0; i < 11; i++)
		begin
			f[i] = line_in;
			repeat (div) @(posedge clk_in);
		end
	endtask : grab
endmodule : sfed_dev_model

// ### bench/tb.sv
`timescale 1ns/1ns
module tb;
	localparam int DIV = 16;
	localparam int GAP = 200;
	logic        clk_sys_in, rst_in, psel, pen, pwr, btn, pready, pslverr, err;
	logic        rxl, txl, store, cmd, prog, pe;
	logic [7:0]  paddr, d, rxd, cmdd;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] fr;
	logic [2:0]  pm;
	logic [7:0]  stq[$];
	int          n_errors = 0, n_tests = 0, ncmd = 0, nb = 8, seed = 32'hefce;

	sfed_top #(.GAP_CYCLES(GAP)) uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.serial_rx_in(rxl), .serial_tx_out(txl), .setup_button_in(btn), .rx_data_out(rxd),
		.rx_store_out(store), .rx_cmd_out(cmd), .prog_mode_out(prog));
	sfed_dev_model dev (.clk_in(clk_sys_in), .line_in(txl), .line_out(rxl));

	initial
	begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in)
	begin
		if (store)
			stq.push_back(rxd);
		if (cmd)
		begin
			cmdd = rxd;
			ncmd++;
		end
	end
	// ================================================================
	// helpers
	function automatic logic par_bit(input logic [2:0] m, input logic [7:0] v, input int n);
		logic [7:0] x;
		x = (n == 7) ? (v & 8'h7F) : v;
		case (m)
			3'h1: return ^x;
			3'h2: return ~^x;
			3'h3: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : par_bit
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_sys_in);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys_in);
		pen <= 1'b1;
		// no own limit: a slave that never answers is caught by the watchdog
		@(posedge clk_sys_in);
		while (pready !== 1'b1)
			@(posedge clk_sys_in);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic ser(input logic [7:0] v, input int gap);
		repeat (gap) @(posedge clk_sys_in);
		dev.send(v, nb, pe, par_bit(pm, v, nb), DIV);
	endtask : ser
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : settle
	task end_of_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	initial
	begin
		settle(40000);
		n_errors++;
		end_of_test;
	end
	// ================================================================
	// main sequence
	initial
	begin
		rst_in = 1'b1;
		{psel, pen, pwr, btn, pe, paddr, pwdata, pm} = '0;
		settle(10);
		rst_in <= 1'b0;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h8);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h20);
		apb(1'b0, 8'h1C, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, 8'h08, DIV);
		// every parity code through the override, last pass with it off
		for (int i = 0; i < 6; i++)
		begin
			d = 8'($random(seed));
			apb(1'b1, 8'h04, (i < 5) ? {28'h0, 3'(i), 1'b1} : 32'h2);
			fork
				dev.grab(DIV, fr);
				apb(1'b1, 8'h14, {24'h0, d});
			join
			chk(fr[8:0], {d, 1'b0});
			chk(fr[9], (i % 5 != 0) ? par_bit(3'(i), d, 8) : 1'b1);
			chk(fr[10], 1'b1);
		end
		repeat (3) ser(8'h01, 300);
		settle(30);
		chk(stq.size(), 3);
		chk(prog, 1'b0);
		btn <= 1'b1;
		settle(10);
		chk(prog, 1'b1);
		apb(1'b1, 8'h00, 32'h18);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd[7:6], 2'h0);
		chk(rd[1], 1'b1);
		btn <= 1'b0;
		apb(1'b1, 8'h0C, 32'h1);
		settle(3);
		chk(prog, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd[7:6], 2'h1);
		// lost counted chars when a short gap breaks the sequence
		stq.delete();
		d = (8'($random(seed)) & 8'h3E) | 8'h40;
		ser(8'h01, 300);
		ser(8'h01, 300);
		ser(8'h01, 20);
		ser(d, 20);
		settle(30);
		chk(stq.size(), 2);
		chk(stq[0], 8'h01);
		chk(stq[1], d);
		repeat (3) ser(8'h01, 300);
		settle(30);
		chk(prog, 1'b1);
		chk(stq.size(), 2);
		apb(1'b1, 8'h00, 32'h21);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd[5:2], 4'h8);
		ser(8'h81, 20);
		settle(30);
		chk(cmdd, 8'h81);
		chk(ncmd, 1);
		apb(1'b1, 8'h0C, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd[7:2], 6'h21);
		// prefix escape with seven bits and even parity
		stq.delete();
		nb = 7;
		pe = 1'b1;
		pm = 3'h1;
		ser(8'h41, 20);
		ser(8'h01, 20);
		ser(8'h01, 20);
		ser(8'h01, 20);
		ser(8'h58, 20);
		settle(30);
		chk(stq.size(), 2);
		chk(stq[0], 8'h41);
		chk(stq[1], 8'h01);
		chk(prog, 1'b1);
		// leave programming mode and send one seven-bit character with even parity
		apb(1'b1, 8'h0C, 32'h1);
		d = 8'($random(seed));
		fork
			dev.grab(DIV, fr);
			apb(1'b1, 8'h14, {24'h0, d});
		join
		chk(fr[7:0], {d[6:0], 1'b0});
		chk(fr[9:8], {1'b1, par_bit(3'h1, d, 7)});
		end_of_test;
	end
endmodule : tb
